/* design/serial_port_pkg.sv */
// shared constants and types for the serial port control upper half
// assumes a 32-bit register port with byte offsets and a 50 MHz clock
package serial_port_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] TX_DATA_OFFSET = 8'h04;
  localparam logic [7:0] PORT_CONTROL_OFFSET = 8'h08;
  localparam logic [7:0] RATE_GEN_CONFIG_OFFSET = 8'h14;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h40;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h44;
  // ----------------------------------------
  // port_control_reg field positions
  // ----------------------------------------
  localparam int RESERVED_TOP_LSB = 26;
  localparam int FREE_RUN_BIT = 25;
  localparam int GRACEFUL_STOP_BIT = 24;
  localparam int FRAMESYNC_GEN_RESET_BIT = 23;
  localparam int RATE_GEN_RESET_BIT = 22;
  localparam int TX_IRQ_SEL_LSB = 20;
  localparam int TX_SYNC_ERROR_BIT = 19;
  localparam int TX_SHIFT_EMPTY_N_BIT = 18;
  localparam int TX_READY_BIT = 17;
  localparam int TX_ENABLE_BIT = 16;
  // ----------------------------------------
  // rate_gen_config_reg fields and register reset values
  // ----------------------------------------
  localparam int RATE_DIV_LSB = 0;
  localparam int RATE_DIV_W = 8;
  localparam int FRAME_PERIOD_LSB = 16;
  localparam int FRAME_PERIOD_W = 12;
  localparam logic [31:0] PORT_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] RATE_GEN_CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] TX_DATA_RESET = 32'h0000_0000;
  // ----------------------------------------
  // interrupt status layout and word timing
  // ----------------------------------------
  localparam int IRQ_W = 3;
  localparam int IRQ_TX_EVENT_BIT = 0;
  localparam int IRQ_FRAME_SYNC_BIT = 1;
  localparam int IRQ_SYNC_ERROR_BIT = 2;
  localparam logic [4:0] TX_LAST_BIT = 5'h1f;
  typedef enum logic [1:0] {
    TX_SRC_READY = 2'h0,
    TX_SRC_RESERVED = 2'h1,
    TX_SRC_FRAME_SYNC = 2'h2,
    TX_SRC_SYNC_ERROR = 2'h3
  } tx_irq_src_t;
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic [FRAME_PERIOD_W-1:0] period;
    logic [RATE_DIV_W-1:0] divider;
  } rate_cfg_t;
  // true when the request address equals the given offset; the caller checks the strobe
  function automatic logic hit(input reg_req_t req, input logic [7:0] off);
    hit = (req.addr == off);
  endfunction
endpackage

/* design/rate_frame_gen.sv */
// sample-rate clock enable and generated frame sync
// assumes the caller gates run_in for emulation halt
`timescale 1ns/10ps
module rate_frame_gen (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  // control
  input wire logic rate_gen_reset_n_in,
  input wire logic framesync_gen_reset_n_in,
  input wire logic run_in,
  input wire serial_port_pkg::rate_cfg_t cfg_in,
  // outputs
  output logic rate_gen_clock_out,
  output logic generated_frame_sync_out
);
  import serial_port_pkg::*;
  logic [RATE_DIV_W-1:0] div_cnt_r;
  logic [FRAME_PERIOD_W-1:0] frame_cnt_r;

  // divider reloads on zero; held at reload while in reset
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      div_cnt_r <= '0;
    else if (clk_en_in)
    begin
      if (!rate_gen_reset_n_in || div_cnt_r == '0)
        div_cnt_r <= cfg_in.divider;
      else if (run_in)
        div_cnt_r <= div_cnt_r - 1'b1;
    end

  // one tick per divider period, none while halted
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      rate_gen_clock_out <= 1'b0;
    else if (clk_en_in)
      rate_gen_clock_out <= rate_gen_reset_n_in && run_in && div_cnt_r == '0;

  // frame counter loads the period while held; first sync after period+1 ticks
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      frame_cnt_r <= '0;
      generated_frame_sync_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      generated_frame_sync_out <= 1'b0;
      if (!framesync_gen_reset_n_in || !rate_gen_reset_n_in)
        frame_cnt_r <= cfg_in.period;
      else if (rate_gen_clock_out)
      begin
        if (frame_cnt_r == '0)
        begin
          generated_frame_sync_out <= 1'b1;
          frame_cnt_r <= cfg_in.period;
        end
        else
          frame_cnt_r <= frame_cnt_r - 1'b1;
      end
    end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_fs_held_load: assert property (!framesync_gen_reset_n_in && clk_en_in |=>
    frame_cnt_r == $past(cfg_in.period) && !generated_frame_sync_out)
    else $error("frame counter not loaded while held");
  a_rate_held: assert property (!rate_gen_reset_n_in && clk_en_in |=> !rate_gen_clock_out)
    else $error("rate clock ticked in reset");
endmodule // rate_frame_gen

/* design/serial_port_ctrl_upper_half.sv */
// port control upper half: emulation clock policy, generator resets,
// transmit interrupt source, sync error and shift status
// assumes a same-clock register port and an emulation halt from a pin
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module serial_port_ctrl_upper_half (
  // clock, enable, reset
  input wire logic clk_in,
  input wire logic clk_en_in,
  input wire logic rst_b_in,
  // register port
  input wire serial_port_pkg::reg_req_t reg_req_in,
  output logic [31:0] rdata_out,
  // emulation halt pin
  input wire logic emu_halt_in,
  // serial side
  output logic dx_out,
  output logic rate_gen_clock_out,
  output logic generated_frame_sync_out,
  // interrupts
  output logic tx_irq_out,
  output logic irq_out
);
  import serial_port_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic free_run_r;
  logic graceful_stop_r;
  logic framesync_gen_reset_n_r;
  logic rate_gen_reset_n_r;
  tx_irq_src_t tx_irq_source_sel_r;
  logic tx_enable_r;
  logic tx_sync_error_r;
  logic tx_sync_error_nxt;
  rate_cfg_t rate_cfg_r;
  logic [31:0] tx_data_reg_r;
  logic tx_data_full_r;
  logic [31:0] tx_shift_reg_r;
  logic [4:0] bit_cnt_r;
  tx_state_t tx_state_r;
  logic halt_meta_r;
  logic halt_sync_r;
  logic clock_run;
  logic hard_abort;
  logic tx_ready_flag;
  logic tx_ready_prev_r;
  logic tx_shift_empty_n;
  logic hw_sync_err;
  logic tx_evt;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_status_nxt;
  logic [IRQ_W-1:0] irq_mask_r;
  logic wr_ctrl;
  logic wr_data;
  logic load_shift;

  assign wr_ctrl = reg_req_in.wr && hit(reg_req_in, PORT_CONTROL_OFFSET);
  assign wr_data = reg_req_in.wr && hit(reg_req_in, TX_DATA_OFFSET);
  assign tx_shift_empty_n = (tx_state_r == TX_SHIFT);
  assign tx_ready_flag = tx_enable_r && !tx_data_full_r;

  // ----------------------------------------
  // emulation halt and clock policy
  // ----------------------------------------
  // halt comes from a pin, so it is synchronised before use
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      halt_meta_r <= 1'b0;
      halt_sync_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      halt_meta_r <= emu_halt_in;
      halt_sync_r <= halt_meta_r;
    end

  // free-run overrides graceful-stop; graceful keeps running while a word shifts
  assign clock_run = free_run_r || !halt_sync_r || (graceful_stop_r && tx_shift_empty_n);
  assign hard_abort = halt_sync_r && !free_run_r && !graceful_stop_r;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  // reserved and read-only bits are simply not stored
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      free_run_r <= PORT_CONTROL_RESET[FREE_RUN_BIT];
      graceful_stop_r <= PORT_CONTROL_RESET[GRACEFUL_STOP_BIT];
      framesync_gen_reset_n_r <= PORT_CONTROL_RESET[FRAMESYNC_GEN_RESET_BIT];
      rate_gen_reset_n_r <= PORT_CONTROL_RESET[RATE_GEN_RESET_BIT];
      tx_irq_source_sel_r <= tx_irq_src_t'(PORT_CONTROL_RESET[TX_IRQ_SEL_LSB +: 2]);
      tx_enable_r <= PORT_CONTROL_RESET[TX_ENABLE_BIT];
    end
    else if (clk_en_in && wr_ctrl)
    begin
      free_run_r <= reg_req_in.wdata[FREE_RUN_BIT];
      graceful_stop_r <= reg_req_in.wdata[GRACEFUL_STOP_BIT];
      framesync_gen_reset_n_r <= reg_req_in.wdata[FRAMESYNC_GEN_RESET_BIT];
      rate_gen_reset_n_r <= reg_req_in.wdata[RATE_GEN_RESET_BIT];
      tx_irq_source_sel_r <= tx_irq_src_t'(reg_req_in.wdata[TX_IRQ_SEL_LSB +: 2]);
      tx_enable_r <= reg_req_in.wdata[TX_ENABLE_BIT];
    end

  // rate generator configuration and interrupt mask
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      rate_cfg_r <= '{period: RATE_GEN_CONFIG_RESET[FRAME_PERIOD_LSB +: FRAME_PERIOD_W],
                      divider: RATE_GEN_CONFIG_RESET[RATE_DIV_LSB +: RATE_DIV_W]};
      irq_mask_r <= '0;
    end
    else if (clk_en_in && reg_req_in.wr)
    begin
      if (hit(reg_req_in, RATE_GEN_CONFIG_OFFSET))
      begin
        rate_cfg_r.period <= reg_req_in.wdata[FRAME_PERIOD_LSB +: FRAME_PERIOD_W];
        rate_cfg_r.divider <= reg_req_in.wdata[RATE_DIV_LSB +: RATE_DIV_W];
      end
      else if (hit(reg_req_in, IRQ_MASK_OFFSET))
        irq_mask_r <= reg_req_in.wdata[IRQ_W-1:0];
    end

  // ----------------------------------------
  // sample-rate and frame-sync generator
  // ----------------------------------------
  rate_frame_gen u_gen (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .rate_gen_reset_n_in(rate_gen_reset_n_r),
    .framesync_gen_reset_n_in(framesync_gen_reset_n_r),
    .run_in(clock_run),
    .cfg_in(rate_cfg_r),
    .rate_gen_clock_out(rate_gen_clock_out),
    .generated_frame_sync_out(generated_frame_sync_out)
  );

  // ----------------------------------------
  // transmit data, shift register and sync error
  // ----------------------------------------
  // a frame sync that finds a word still shifting is a sync error
  assign hw_sync_err = tx_enable_r && generated_frame_sync_out && tx_shift_empty_n;
  assign load_shift = tx_enable_r && generated_frame_sync_out && !tx_shift_empty_n
                      && tx_data_full_r && !hard_abort;

  // data register; a write in the load cycle wins and stays pending
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      tx_data_reg_r <= TX_DATA_RESET;
      tx_data_full_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (!tx_enable_r)
        tx_data_full_r <= 1'b0;
      else if (wr_data)
      begin
        tx_data_reg_r <= reg_req_in.wdata;
        tx_data_full_r <= 1'b1;
      end
      else if (load_shift)
        tx_data_full_r <= 1'b0;
    end

  // shifter: msb first, one bit per rate tick; hard halt drops the word
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      tx_state_r <= TX_IDLE;
      tx_shift_reg_r <= '0;
      bit_cnt_r <= '0;
      dx_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      case (tx_state_r)
        TX_IDLE:
        begin
          if (load_shift)
          begin
            tx_state_r <= TX_SHIFT;
            tx_shift_reg_r <= tx_data_reg_r;
            bit_cnt_r <= TX_LAST_BIT;
          end
        end
        TX_SHIFT:
        begin
          if (!tx_enable_r || hard_abort)
            tx_state_r <= TX_IDLE;
          else if (rate_gen_clock_out)
          begin
            dx_out <= tx_shift_reg_r[31];
            tx_shift_reg_r <= {tx_shift_reg_r[30:0], 1'b0};
            bit_cnt_r <= bit_cnt_r - 1'b1;
            if (bit_cnt_r == '0)
              tx_state_r <= TX_IDLE;
          end
        end
        default:
          tx_state_r <= TX_IDLE;
      endcase
    end

  // error flag: hardware or a one written while enabled sets; a zero clears; set wins
  always_comb
  begin
    tx_sync_error_nxt = tx_sync_error_r;
    if (wr_ctrl && !reg_req_in.wdata[TX_SYNC_ERROR_BIT])
      tx_sync_error_nxt = 1'b0;
    if (hw_sync_err || (wr_ctrl && tx_enable_r && reg_req_in.wdata[TX_SYNC_ERROR_BIT]))
      tx_sync_error_nxt = 1'b1;
    if (!tx_enable_r)
      tx_sync_error_nxt = 1'b0;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      tx_sync_error_r <= PORT_CONTROL_RESET[TX_SYNC_ERROR_BIT];
    else if (clk_en_in)
      tx_sync_error_r <= tx_sync_error_nxt;

  // ----------------------------------------
  // interrupt source and sticky status
  // ----------------------------------------
  // the reserved source value raises nothing
  always_comb
  begin
    case (tx_irq_source_sel_r)
      TX_SRC_READY: tx_evt = tx_ready_flag && !tx_ready_prev_r;
      TX_SRC_FRAME_SYNC: tx_evt = generated_frame_sync_out;
      TX_SRC_SYNC_ERROR: tx_evt = tx_sync_error_nxt && !tx_sync_error_r;
      default: tx_evt = 1'b0;
    endcase
  end

  // write one clears; a new event in the same cycle keeps the bit set
  always_comb
  begin
    irq_status_nxt = irq_status_r;
    if (reg_req_in.wr && hit(reg_req_in, IRQ_STATUS_OFFSET))
      irq_status_nxt = irq_status_r & ~reg_req_in.wdata[IRQ_W-1:0];
    if (tx_evt)
      irq_status_nxt[IRQ_TX_EVENT_BIT] = 1'b1;
    if (generated_frame_sync_out)
      irq_status_nxt[IRQ_FRAME_SYNC_BIT] = 1'b1;
    if (tx_sync_error_nxt && !tx_sync_error_r)
      irq_status_nxt[IRQ_SYNC_ERROR_BIT] = 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      irq_status_r <= '0;
      irq_out <= 1'b0;
      tx_irq_out <= 1'b0;
      tx_ready_prev_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      irq_status_r <= irq_status_nxt;
      irq_out <= |(irq_status_nxt & irq_mask_r);
      tx_irq_out <= tx_evt;
      tx_ready_prev_r <= tx_ready_flag;
    end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // data stands only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      rdata_out <= '0;
    else if (clk_en_in)
    begin
      rdata_out <= '0;
      if (reg_req_in.rd)
      begin
        if (hit(reg_req_in, PORT_CONTROL_OFFSET))
        begin
          rdata_out[FREE_RUN_BIT] <= free_run_r;
          rdata_out[GRACEFUL_STOP_BIT] <= graceful_stop_r;
          rdata_out[FRAMESYNC_GEN_RESET_BIT] <= framesync_gen_reset_n_r;
          rdata_out[RATE_GEN_RESET_BIT] <= rate_gen_reset_n_r;
          rdata_out[TX_IRQ_SEL_LSB +: 2] <= tx_irq_source_sel_r;
          rdata_out[TX_SYNC_ERROR_BIT] <= tx_sync_error_r;
          rdata_out[TX_SHIFT_EMPTY_N_BIT] <= tx_shift_empty_n;
          rdata_out[TX_READY_BIT] <= tx_ready_flag;
          rdata_out[TX_ENABLE_BIT] <= tx_enable_r;
        end
        else if (hit(reg_req_in, TX_DATA_OFFSET))
          rdata_out <= tx_data_reg_r;
        else if (hit(reg_req_in, RATE_GEN_CONFIG_OFFSET))
        begin
          rdata_out[FRAME_PERIOD_LSB +: FRAME_PERIOD_W] <= rate_cfg_r.period;
          rdata_out[RATE_DIV_LSB +: RATE_DIV_W] <= rate_cfg_r.divider;
        end
        else if (hit(reg_req_in, IRQ_STATUS_OFFSET))
          rdata_out[IRQ_W-1:0] <= irq_status_r;
        else if (hit(reg_req_in, IRQ_MASK_OFFSET))
          rdata_out[IRQ_W-1:0] <= irq_mask_r;
      end
    end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_ctrl_read;
    clk_en_in && reg_req_in.rd && reg_req_in.addr == PORT_CONTROL_OFFSET;
  endsequence
  sequence s_hard_halt;
    clk_en_in && halt_sync_r && !free_run_r && !graceful_stop_r;
  endsequence
  a_reserved_zero: assert property (s_ctrl_read |=> rdata_out[31:RESERVED_TOP_LSB] == '0)
    else $error("reserved control bits read nonzero");
  a_free_runs: assert property (free_run_r |-> clock_run)
    else $error("serial clock stopped in free-run");
  a_hard_stop: assert property (s_hard_halt |=> !tx_shift_empty_n && !rate_gen_clock_out)
    else $error("transfer survived a hard halt");
  a_soft_finish: assert property (halt_sync_r && !free_run_r && graceful_stop_r && tx_shift_empty_n
    |-> clock_run)
    else $error("graceful halt stopped mid word");
  a_fs_gated: assert property (!framesync_gen_reset_n_r && clk_en_in |=> !generated_frame_sync_out)
    else $error("frame sync while generator held");
  a_src_frame: assert property (clk_en_in && tx_irq_source_sel_r == TX_SRC_FRAME_SYNC
    && generated_frame_sync_out |=> tx_irq_out)
    else $error("frame sync source raised no interrupt");
  a_src_reserved: assert property (clk_en_in && tx_irq_source_sel_r == TX_SRC_RESERVED |=> !tx_irq_out)
    else $error("reserved source raised an interrupt");
  a_force_error: assert property (clk_en_in && wr_ctrl && tx_enable_r
    && reg_req_in.wdata[TX_SYNC_ERROR_BIT] |=> tx_sync_error_r)
    else $error("forced sync error not set");
  a_empty_status: assert property (s_ctrl_read |=> rdata_out[TX_SHIFT_EMPTY_N_BIT] == $past(tx_shift_empty_n))
    else $error("shift status misreported");
  a_tx_disabled: assert property (!tx_enable_r && clk_en_in |=> !tx_shift_empty_n && !tx_sync_error_r)
    else $error("transmitter active while disabled");
  a_ready_drop: assert property (clk_en_in && wr_data && tx_ready_flag |=> !tx_ready_flag || !tx_enable_r)
    else $error("ready stayed high after a data write");
endmodule // serial_port_ctrl_upper_half

/* verification/serial_port_ctrl_upper_half_tb_top.sv */
// self-checking bench for the port control upper half
// assumes the register port map and timing of the package, one 50 MHz clock
`timescale 1ns/10ps
module serial_port_ctrl_upper_half_tb_top;
  import serial_port_pkg::*;
  // ----------------------------------------
  // signals and counters
  // ----------------------------------------
  localparam logic [31:0] GEN = 32'h1 << RATE_GEN_RESET_BIT;
  localparam logic [31:0] GENERATED_FRAME_SYNC = 32'h1 << FRAMESYNC_GEN_RESET_BIT;
  localparam logic [31:0] TXE = 32'h1 << TX_ENABLE_BIT;
  localparam logic [31:0] FREE = 32'h1 << FREE_RUN_BIT;
  localparam logic [31:0] SOFT = 32'h1 << GRACEFUL_STOP_BIT;
  localparam logic [31:0] SERR = 32'h1 << TX_SYNC_ERROR_BIT;
  logic clk_in, rst_b_in, emu_halt_in;
  reg_req_t req;
  logic [31:0] rdata, dx_word;
  logic dx, rclk, fsync, tx_irq, irq, rclk_d, clk_en;
  int mismatches, checked, cyc, n_rate, n_fs, n_tx, rate_gap, fs_gap, rate_last, fs_last;

  serial_port_ctrl_upper_half i_serial_port_ctrl_upper_half (
    .clk_in(clk_in), .clk_en_in(clk_en), .rst_b_in(rst_b_in), .reg_req_in(req), .rdata_out(rdata),
    .emu_halt_in(emu_halt_in), .dx_out(dx), .rate_gen_clock_out(rclk),
    .generated_frame_sync_out(fsync), .tx_irq_out(tx_irq), .irq_out(irq));

  // free-running clock, 20 ns period
  always #10 clk_in = ~clk_in;

  // pulse counters sampled mid-cycle, where outputs have settled
  always @(negedge clk_in)
  begin
    cyc++;
    if (rclk === 1'b1)
    begin
      rate_gap = cyc - rate_last;
      rate_last = cyc;
      n_rate++;
    end
    if (fsync === 1'b1)
    begin
      fs_gap = cyc - fs_last;
      fs_last = cyc;
      n_fs++;
    end
    if (tx_irq === 1'b1) n_tx++;
    // a serial bit lands on the edge after its tick, so it is taken one negedge later
    if (rclk_d) dx_word = {dx_word[30:0], dx};
    rclk_d = (rclk === 1'b1);
  end

  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask

  // read data is taken in the one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(name, d & m, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic clr();
    n_rate = 0;
    n_fs = 0;
    n_tx = 0;
    rate_gap = 0;
    fs_gap = 0;
  endtask

  // bounded poll of the shift status bit
  task automatic wait_shift(input logic want);
    logic [31:0] d;
    for (int i = 0; i < 100; i++)
    begin
      rd(PORT_CONTROL_OFFSET, d);
      if (d[TX_SHIFT_EMPTY_N_BIT] === want) break;
    end
    check("shift_status", {31'h0, d[TX_SHIFT_EMPTY_N_BIT]}, {31'h0, want});
  endtask

  task final_report();
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // watchdog: whole run is about 450 cycles
  // ----------------------------------------
  initial
  begin
    #400000;
    mismatches++;
    final_report();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    clk_in = 1'b0;
    rst_b_in = 1'b0;
    emu_halt_in = 1'b0;
    req = '0;
    clk_en = 1'b1;
    rclk_d = 1'b0;
    dx_word = '0;
    idle(5);
    rst_b_in <= 1'b1;
    // reset values and an unmapped place
    rdchk("control", PORT_CONTROL_OFFSET, 32'hffff_ffff, PORT_CONTROL_RESET);
    rdchk("rate_cfg", RATE_GEN_CONFIG_OFFSET, 32'hffff_ffff, RATE_GEN_CONFIG_RESET);
    rdchk("status", IRQ_STATUS_OFFSET, 32'hffff_ffff, 32'h0);
    wr(8'h3c, 32'hffff_ffff);
    rdchk("unmapped", 8'h3c, 32'hffff_ffff, 32'h0);
    // all ones with transmitter off: reserved stay zero, error not forced
    wr(PORT_CONTROL_OFFSET, 32'hfffe_ffff);
    rdchk("control_ones", PORT_CONTROL_OFFSET, 32'hfffd_ffff, 32'h03f0_0000);
    // forced sync error with source 3
    wr(PORT_CONTROL_OFFSET, TXE | 32'h0030_0000);
    clr();
    wr(PORT_CONTROL_OFFSET, TXE | 32'h0030_0000 | SERR);
    rdchk("sync_err_set", PORT_CONTROL_OFFSET, SERR, SERR);
    idle(3);
    check("tx_irq_syncerr", n_tx, 1);
    rdchk("status_err", IRQ_STATUS_OFFSET, 32'h4, 32'h4);
    wr(PORT_CONTROL_OFFSET, TXE | 32'h0030_0000);
    rdchk("sync_err_clr", PORT_CONTROL_OFFSET, SERR, 32'h0);
    wr(IRQ_STATUS_OFFSET, 32'h7);
    // rate generator held, then divider 3 with frame period 4
    wr(PORT_CONTROL_OFFSET, 32'h0);
    wr(RATE_GEN_CONFIG_OFFSET, 32'h0004_0003);
    clr();
    idle(20);
    check("rate_held", n_rate, 0);
    wr(PORT_CONTROL_OFFSET, GEN);
    clr();
    idle(40);
    check("rate_gap", rate_gap, 4);
    check("fs_held", n_fs, 0);
    // frame sync every 5 ticks of 4 cycles, tx irq on frame sync
    wr(IRQ_MASK_OFFSET, 32'h2);
    wr(PORT_CONTROL_OFFSET, GENERATED_FRAME_SYNC | GEN | 32'h0020_0000);
    clr();
    idle(70);
    check("fs_gap", fs_gap, 20);
    check("tx_irq_fs", n_tx, n_fs);
    check("irq_level", {31'h0, irq}, 32'h1);
    rdchk("status_fs", IRQ_STATUS_OFFSET, 32'h2, 32'h2);
    wr(IRQ_MASK_OFFSET, 32'h0);
    idle(2);
    check("irq_masked", {31'h0, irq}, 32'h0);
    // reserved source raises nothing
    wr(PORT_CONTROL_OFFSET, GENERATED_FRAME_SYNC | GEN | 32'h0010_0000);
    // let a pulse launched under the old source drain before counting
    idle(2);
    clr();
    idle(50);
    check("tx_irq_rsvd", n_tx, 0);
    wr(PORT_CONTROL_OFFSET, GEN);
    idle(2);
    wr(IRQ_STATUS_OFFSET, 32'h7);
    rdchk("status_w1c", IRQ_STATUS_OFFSET, 32'hffff_ffff, 32'h0);
    // emulation halt with free-run (graceful bit set but ignored)
    wr(PORT_CONTROL_OFFSET, FREE | SOFT | GEN);
    emu_halt_in <= 1'b1;
    idle(6);
    clr();
    idle(20);
    check("free_run", n_rate, 5);
    wr(PORT_CONTROL_OFFSET, GEN);
    idle(6);
    clr();
    idle(20);
    check("hard_halt", n_rate, 0);
    emu_halt_in <= 1'b0;
    idle(6);
    clr();
    idle(20);
    check("resume", n_rate, 5);
    // one word through the shifter, graceful halt mid-word
    wr(PORT_CONTROL_OFFSET, 32'h0);
    // a write while the clock enable is low must leave no trace
    clk_en <= 1'b0;
    wr(PORT_CONTROL_OFFSET, GEN);
    clk_en <= 1'b1;
    rdchk("frozen", PORT_CONTROL_OFFSET, 32'hffff_ffff, 32'h0);
    wr(RATE_GEN_CONFIG_OFFSET, 32'h0027_0000);
    wr(PORT_CONTROL_OFFSET, SOFT | GENERATED_FRAME_SYNC | GEN | TXE);
    idle(3);
    clr();
    wr(TX_DATA_OFFSET, 32'ha5c3_0f01);
    wait_shift(1'b1);
    rdchk("ready_again", PORT_CONTROL_OFFSET, 32'h0006_0000, 32'h0006_0000);
    check("tx_irq_ready", n_tx, 1);
    clr();
    emu_halt_in <= 1'b1;
    wait_shift(1'b0);
    check("soft_ticks", {31'h0, n_rate > 20}, 32'h1);
    idle(6);
    clr();
    idle(20);
    check("soft_stop", n_rate, 0);
    // msb first; the tick already launched as the word ends repeats bit 0
    check("dx_word", dx_word, 32'h4b86_1e03);
    emu_halt_in <= 1'b0;
    final_report();
  end
endmodule // serial_port_ctrl_upper_half_tb_top
